// file: logic/dpa_pkg.sv
// Purpose: shared constants for the dual product slice and its register file
// Assumes: AXI4-Lite slave with 32-bit data and byte addresses
// Notes: every offset, field position and reset value lives here
`default_nettype none

package dpa_pkg;
    // ========================================
    // register bus geometry
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS = 8'h08;
    localparam logic [7:0] RESULT_LO_OFS = 8'h0c;
    localparam logic [7:0] RESULT_HI_OFS = 8'h10;

    // ========================================
    // control register fields
    localparam int CTRL_W = 4;
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_IN_REG_BIT = 1;
    localparam int CTRL_PIPE_REG_BIT = 2;
    localparam int CTRL_OUT_REG_BIT = 3;
    localparam int CTRL_ACC_CLR_BIT = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'he;

    // ========================================
    // status and mask fields
    localparam int STAT_W = 1;
    localparam int STAT_OVF_BIT = 0;
    localparam logic [STAT_W-1:0] STATUS_RESET = 1'h0;
    localparam logic [STAT_W-1:0] MASK_RESET = 1'h0;

    // ========================================
    // register selector codes
    typedef enum logic [2:0] {
        SEL_CTRL = 3'h0,
        SEL_STATUS = 3'h1,
        SEL_MASK = 3'h2,
        SEL_RES_LO = 3'h3,
        SEL_RES_HI = 3'h4,
        SEL_NONE = 3'h7
    } dpa_sel_e;

    // element configurations
    typedef enum logic {
        MODE_ACCUM = 1'h0,
        MODE_ADDSUB = 1'h1
    } dpa_mode_e;
endpackage

`default_nettype wire

// file: logic/dpa_opt_stage.sv
// Purpose: one optional register stage that may be bypassed
// Assumes: single clock, synchronous active high reset
// Notes: register loads every cycle; bypass only picks the output
`default_nettype none

module dpa_opt_stage #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic bypass,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage_reg;
    logic [W-1:0] stage_next;

    // ========================================
    // next value: always follow the input
    always_comb begin
        stage_next = d;
    end

    // register only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stage_reg <= '0;
        end else begin
            stage_reg <= stage_next;
        end
    end

    // bypass selects the live input
    assign q = bypass ? d : stage_reg;
endmodule

`default_nettype wire

// file: logic/dpa_slice.sv
// Purpose: signed slice with two multipliers, accumulate or add/subtract
// Assumes: operands come from logic on core_clk; registers over AXI4-Lite
// Notes: result is combinational only when add/subtract bypasses its output stage
//
// What this block does
// - in accumulate mode each enabled cycle that meets no clear adds both products to the held total; a clear in that cycle zeroes it and drops the sample.
// - in accumulate mode the output register always holds the running total.
// - in accumulate mode input and pipeline stages are each registered or bypassed.
// - in accumulate mode overflow is registered together with the total.
// - in add/subtract mode the result is product one plus or minus product two.
// - in add/subtract mode input, pipeline and output stages are each selectable.
`default_nettype none

module dpa_slice
    import dpa_pkg::*;
#(
    parameter int OP_W = 18,
    parameter int ACC_W = 54
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sampleEn,
    input wire logic subtractSel,
    input wire logic signed [OP_W-1:0] pairOneOperandX,
    input wire logic signed [OP_W-1:0] pairOneOperandY,
    input wire logic signed [OP_W-1:0] pairTwoOperandX,
    input wire logic signed [OP_W-1:0] pairTwoOperandY,
    output logic [ACC_W-1:0] resultOut,
    output logic resultValid,
    output logic overflowFlag,
    output logic irq
);
    localparam int P_W = 2 * OP_W;
    localparam int S1_W = 2 + 4 * OP_W;
    localparam int S2_W = 2 + 2 * P_W;
    localparam int SUM_W = ACC_W + 2;

    // map a byte address onto a register selector
    function automatic dpa_sel_e regSel(input logic [AXI_ADDR_W-1:0] a);
        case (a)
            CTRL_OFS: regSel = SEL_CTRL;
            STATUS_OFS: regSel = SEL_STATUS;
            MASK_OFS: regSel = SEL_MASK;
            RESULT_LO_OFS: regSel = SEL_RES_LO;
            RESULT_HI_OFS: regSel = SEL_RES_HI;
            default: regSel = SEL_NONE;
        endcase
    endfunction

    // ========================================
    // register file and bus state
    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [STAT_W-1:0] status_reg, status_next;
    logic [STAT_W-1:0] mask_reg, mask_next;
    logic irq_reg, irq_next;
    logic awHeld_reg, awHeld_next;
    logic [AXI_ADDR_W-1:0] awAddr_reg, awAddr_next;
    logic wHeld_reg, wHeld_next;
    logic [AXI_DATA_W-1:0] wData_reg, wData_next;
    logic [3:0] wStrb_reg, wStrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [AXI_DATA_W-1:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic accClr;
    logic ovfEvent;

    // ========================================
    // datapath state
    logic [S1_W-1:0] s1In, s1Out;
    logic [S2_W-1:0] s2In, s2Out;
    logic signed [P_W-1:0] prodOne, prodTwo, pOne, pTwo;
    logic s1Valid, s1Sub, pValid, pSub;
    logic signed [OP_W-1:0] xOne, yOne, xTwo, yTwo;
    logic [ACC_W-1:0] result_reg, result_next;
    logic valid_reg, valid_next;
    logic ovf_reg, ovf_next;
    logic signed [SUM_W-1:0] accSum;
    logic accOvf;
    logic signed [ACC_W-1:0] addSubVal;
    logic signed [SUM_W-1:0] oneWide, twoWide, addSubWide;
    logic [63:0] res64;
    dpa_mode_e mode;
    logic outBypass;

    assign mode = dpa_mode_e'(ctrl_reg[CTRL_MODE_BIT]);

    // ========================================
    // input stage: operands and add/subtract select
    assign s1In = {sampleEn, subtractSel, pairOneOperandX, pairOneOperandY,
                   pairTwoOperandX, pairTwoOperandY};

    dpa_opt_stage #(.W(S1_W)) inStage (
        .core_clk(core_clk),
        .rst(rst),
        .bypass(~ctrl_reg[CTRL_IN_REG_BIT]),
        .d(s1In),
        .q(s1Out)
    );

    assign {s1Valid, s1Sub, xOne, yOne, xTwo, yTwo} = s1Out;

    // two signed multipliers
    assign prodOne = xOne * yOne;
    assign prodTwo = xTwo * yTwo;

    // ========================================
    // pipeline stage between multipliers and adder
    assign s2In = {s1Valid, s1Sub, prodOne, prodTwo};

    dpa_opt_stage #(.W(S2_W)) pipeStage (
        .core_clk(core_clk),
        .rst(rst),
        .bypass(~ctrl_reg[CTRL_PIPE_REG_BIT]),
        .d(s2In),
        .q(s2Out)
    );

    assign {pValid, pSub, pOne, pTwo} = s2Out;

    // products sign-extended once to the guarded sum width
    assign oneWide = $signed({{(SUM_W-P_W){pOne[P_W-1]}}, pOne});
    assign twoWide = $signed({{(SUM_W-P_W){pTwo[P_W-1]}}, pTwo});

    // accumulate sum with two guard bits for overflow
    assign accSum = $signed({{2{result_reg[ACC_W-1]}}, result_reg}) + oneWide + twoWide;
    assign accOvf = (accSum[SUM_W-1:ACC_W-1] != {3{accSum[ACC_W-1]}});

    // add or subtract, no history; the sum is cut to ACC_W bits and wraps when products fill the result
    assign addSubWide = pSub ? (oneWide - twoWide) : (oneWide + twoWide);
    assign addSubVal = addSubWide[ACC_W-1:0];

    // ========================================
    // output stage next values
    always_comb begin
        result_next = result_reg;
        valid_next = 1'b0;
        ovf_next = ovf_reg;
        ovfEvent = 1'b0;
        case (mode)
            MODE_ACCUM: begin
                if (accClr) begin
                    result_next = '0;
                    ovf_next = 1'b0;
                end else if (pValid) begin
                    result_next = accSum[ACC_W-1:0];
                    valid_next = 1'b1;
                    ovf_next = accOvf;
                    ovfEvent = accOvf;
                end
            end
            MODE_ADDSUB: begin
                ovf_next = 1'b0;
                if (pValid) begin
                    result_next = addSubVal;
                    valid_next = 1'b1;
                end
            end
            default: begin
                result_next = result_reg;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            result_reg <= '0;
            valid_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            result_reg <= result_next;
            valid_reg <= valid_next;
            ovf_reg <= ovf_next;
        end
    end

    // output stage bypass exists only for add/subtract
    assign outBypass = (mode == MODE_ADDSUB) && !ctrl_reg[CTRL_OUT_REG_BIT];
    assign resultOut = outBypass ? addSubVal : result_reg;
    assign resultValid = outBypass ? pValid : valid_reg;
    assign overflowFlag = ovf_reg;
    assign irq = irq_reg;

    // ========================================
    // register bus next values
    always_comb begin
        ctrl_next = ctrl_reg;
        status_next = status_reg;
        mask_next = mask_reg;
        awHeld_next = awHeld_reg;
        awAddr_next = awAddr_reg;
        wHeld_next = wHeld_reg;
        wData_next = wData_reg;
        wStrb_next = wStrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        arready_next = 1'b1;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        accClr = 1'b0;
        res64 = 64'(signed'(result_reg));
        // capture address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_next = 1'b1;
            awAddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_next = 1'b1;
            wData_next = s_axi_wdata;
            wStrb_next = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        // commit once both halves are held
        if (awHeld_reg && wHeld_reg && !bvalid_reg) begin
            awHeld_next = 1'b0;
            wHeld_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            case (regSel(awAddr_reg))
                SEL_CTRL: begin
                    if (wStrb_reg[0]) begin
                        ctrl_next = wData_reg[CTRL_W-1:0];
                        accClr = wData_reg[CTRL_ACC_CLR_BIT];
                    end
                end
                SEL_STATUS: begin
                    if (wStrb_reg[0]) begin
                        status_next = status_reg & ~wData_reg[STAT_W-1:0];
                    end
                end
                SEL_MASK: begin
                    if (wStrb_reg[0]) begin
                        mask_next = wData_reg[STAT_W-1:0];
                    end
                end
                SEL_RES_LO, SEL_RES_HI: begin
                    bresp_next = RESP_OKAY;
                end
                default: begin
                    bresp_next = RESP_SLVERR;
                end
            endcase
        end
        // overflow sets the sticky bit, winning over a clear
        if (ovfEvent) begin
            status_next[STAT_OVF_BIT] = 1'b1;
        end
        irq_next = |(status_next & mask_next);
        // reads answer one cycle after acceptance
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = '0;
            case (regSel(s_axi_araddr))
                SEL_CTRL: rdata_next[CTRL_W-1:0] = ctrl_reg;
                SEL_STATUS: rdata_next[STAT_W-1:0] = status_reg;
                SEL_MASK: rdata_next[STAT_W-1:0] = mask_reg;
                SEL_RES_LO: rdata_next = res64[31:0];
                SEL_RES_HI: rdata_next = res64[63:32];
                default: rresp_next = RESP_SLVERR;
            endcase
        end
        // address ready only while no read answer stands
        if (rvalid_next) begin
            arready_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            status_reg <= STATUS_RESET;
            mask_reg <= MASK_RESET;
            irq_reg <= 1'b0;
            awHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wHeld_reg <= 1'b0;
            wData_reg <= '0;
            wStrb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            awHeld_reg <= awHeld_next;
            awAddr_reg <= awAddr_next;
            wHeld_reg <= wHeld_next;
            wData_reg <= wData_next;
            wStrb_reg <= wStrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            s_axi_awready <= !awHeld_next && !bvalid_next;
            s_axi_wready <= !wHeld_next && !bvalid_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule

`default_nettype wire

// file: test/dpa_slice_chk.sv
// Purpose: port checker for dpa_slice
// Assumes: one clock, synchronous active high reset
// Notes: stage settings are not visible here, so latency is bounded
`default_nettype none

module dpa_slice_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sampleEn,
    input wire logic resultValid,
    input wire logic overflowFlag,
    input wire logic irq
);
    // ========================================
    // bus and datapath relations
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic wTake;
    // write data taken this cycle
    assign wTake = s_axi_wvalid && s_axi_wready;
    AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not closed");
    AST_B_NEXT: assert property (s_axi_awvalid && s_axi_awready && wTake |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    AST_LAT: assert property (sampleEn |-> ##[0:3] resultValid)
        else $error("result missing");
    AST_OVF_RISE: assert property ($rose(overflowFlag) |-> resultValid)
        else $error("overflow off the result");
    AST_OVF_FALL: assert property ($fell(overflowFlag) |-> resultValid || $past(wTake)
        || $past(wTake, 2) || $past(wTake, 3)) else $error("overflow lost");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wTake, 2) || $past(wTake, 3))
        else $error("irq fell alone");
    cover property (resultValid && overflowFlag);
    cover property ($fell(irq));
    cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind dpa_slice dpa_slice_chk u_chk (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sampleEn, .resultValid,
    .overflowFlag, .irq);

`default_nettype wire

// file: test/dpa_fabric_model.sv
// Purpose: fabric model feeding operands and taking results
// Assumes: the bench calls send and idle right after an edge
// Notes: released operand lines show inverted data
`default_nettype none

module dpa_fabric_model #(
    parameter int OP_W = 18,
    parameter int ACC_W = 54
) (
    input wire logic core_clk,
    output logic sampleEn,
    output logic subtractSel,
    output logic [OP_W-1:0] pairOneOperandX,
    output logic [OP_W-1:0] pairOneOperandY,
    output logic [OP_W-1:0] pairTwoOperandX,
    output logic [OP_W-1:0] pairTwoOperandY,
    input wire logic [ACC_W-1:0] resultOut,
    input wire logic resultValid
);
    // ========================================
    // drive and capture
    int nSent = 0;
    int nRes = 0;
    int cyc = 0;
    int lastLat = 0;
    int stampQ[$];
    logic [ACC_W-1:0] resQ[$];
    // quiet lines at time zero
    initial begin
        sampleEn = 1'b0;
        subtractSel = 1'b0;
        {pairOneOperandX, pairOneOperandY, pairTwoOperandX, pairTwoOperandY} = '0;
    end
    // one sample; the select rides with its operands
    task automatic send(input logic [OP_W-1:0] a, b, c, d, input logic sub);
        sampleEn <= 1'b1;
        subtractSel <= sub;
        pairOneOperandX <= a;
        pairOneOperandY <= b;
        pairTwoOperandX <= c;
        pairTwoOperandY <= d;
        nSent++;
        @(posedge core_clk);
    endtask
    // release: stale values are inverted
    task automatic idle();
        sampleEn <= 1'b0;
        subtractSel <= ~subtractSel;
        pairOneOperandX <= ~pairOneOperandX;
        pairOneOperandY <= ~pairOneOperandY;
        pairTwoOperandX <= ~pairTwoOperandX;
        pairTwoOperandY <= ~pairTwoOperandY;
        @(posedge core_clk);
    endtask
    // edges from sample to result
    always @(posedge core_clk) begin
        if (sampleEn === 1'b1)
            stampQ.push_back(cyc);
        if (resultValid === 1'b1 && stampQ.size() > 0) begin
            lastLat = cyc - stampQ.pop_front();
            resQ.push_back(resultOut);
            nRes++;
        end
        cyc++;
    end
endmodule

`default_nettype wire

// file: test/test_dual_multiply_accumulate_slice.sv
// Purpose: bench for the dual product slice
// Assumes: fabric model drives operands; registers over AXI4-Lite
// Notes: accumulator narrowed to 36 bits so one sample overflows
`default_nettype none

module test_dual_multiply_accumulate_slice import dpa_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ACC_W = 36;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic sampleEn, subtractSel, resultValid, overflowFlag, irq;
    logic [17:0] pairOneOperandX, pairOneOperandY, pairTwoOperandX, pairTwoOperandY;
    logic [ACC_W-1:0] resultOut;
    int mismatches = 0;
    int nTests = 0;
    int cycles = 0;

    // ========================================
    // design, fabric model, clock
    dpa_slice #(.ACC_W(ACC_W)) DUT (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sampleEn, .subtractSel, .pairOneOperandX, .pairOneOperandY, .pairTwoOperandX,
        .pairTwoOperandY, .resultOut, .resultValid, .overflowFlag, .irq);
    dpa_fabric_model #(.ACC_W(ACC_W)) fab (.core_clk, .sampleEn, .subtractSel,
        .pairOneOperandX, .pairOneOperandY, .pairTwoOperandX, .pairTwoOperandY,
        .resultOut, .resultValid);
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tallyAndFinish();
        end
    end

    // ========================================
    // bus cycles and comparison
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        nTests++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        fork
            begin
                do @(posedge core_clk); while (s_axi_awready !== 1'b1);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge core_clk); while (s_axi_wready !== 1'b1);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        chk("bresp", er, s_axi_bresp);
        s_axi_bready <= 1'b1;
        @(posedge core_clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        s_axi_rready <= 1'b1;
        @(posedge core_clk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic drain();
        for (int i = 0; i < 20 && fab.nRes < fab.nSent; i++)
            @(posedge core_clk);
    endtask
    task automatic pop(input logic [63:0] e);
        logic [63:0] g;
        g = 64'hx;
        if (fab.resQ.size() > 0)
            g = fab.resQ.pop_front();
        chk("result", e, g);
    endtask

    // ========================================
    // scenarios
    task automatic testRegs();
        rd(CTRL_OFS, 32'he, RESP_OKAY);
        rd(STATUS_OFS, 32'h0, RESP_OKAY);
        rd(MASK_OFS, 32'h0, RESP_OKAY);
        rd(8'h14, 32'h0, RESP_SLVERR);
        wr(8'h14, 32'h1, RESP_SLVERR);
        wr(RESULT_LO_OFS, 32'h5, RESP_OKAY);
        rd(RESULT_LO_OFS, 32'h0, RESP_OKAY);
        $display("testRegs done");
    endtask
    task automatic testAccum();
        wr(CTRL_OFS, 32'h16, RESP_OKAY);
        fab.send(18'h3, 18'h4, 18'h5, 18'h3fffa, 1'b0);
        fab.send(18'h3fff9, 18'h8, 18'h64, 18'h2, 1'b0);
        fab.idle();
        drain();
        pop(36'hfffffffee);
        pop(36'h7e);
        chk("lat", 3, fab.lastLat);
        rd(RESULT_LO_OFS, 32'h7e, RESP_OKAY);
        wr(CTRL_OFS, 32'h10, RESP_OKAY);
        fab.send(18'h3fffe, 18'h3, 18'h0, 18'h0, 1'b0);
        fab.send(18'h1, 18'h1, 18'h1, 18'h1, 1'b0);
        fab.idle();
        drain();
        pop(36'hffffffffa);
        pop(36'hffffffffc);
        chk("lat", 1, fab.lastLat);
        rd(RESULT_HI_OFS, 32'hffffffff, RESP_OKAY);
        $display("testAccum done");
    endtask
    task automatic testOvf();
        wr(CTRL_OFS, 32'h10, RESP_OKAY);
        fab.send(18'h20000, 18'h20000, 18'h20000, 18'h20000, 1'b0);
        fab.idle();
        drain();
        pop(36'h800000000);
        chk("ovf", 1'b1, overflowFlag);
        rd(STATUS_OFS, 32'h1, RESP_OKAY);
        chk("irq", 1'b0, irq);
        wr(MASK_OFS, 32'h1, RESP_OKAY);
        chk("irq", 1'b1, irq);
        wr(CTRL_OFS, 32'h10, RESP_OKAY);
        chk("ovf", 1'b0, overflowFlag);
        wr(STATUS_OFS, 32'h1, RESP_OKAY);
        rd(STATUS_OFS, 32'h0, RESP_OKAY);
        chk("irq", 1'b0, irq);
        $display("testOvf done");
    endtask
    task automatic testAddSub();
        logic [3:0] cfg[4];
        int lat[4];
        cfg = '{4'h1, 4'hf, 4'h5, 4'hb};
        lat = '{0, 3, 1, 2};
        for (int i = 0; i < 4; i++) begin
            wr(CTRL_OFS, {28'h0, cfg[i]}, RESP_OKAY);
            fab.send(18'h5, 18'h6, 18'h7, 18'h3fffd, 1'b0);
            fab.send(18'h5, 18'h6, 18'h7, 18'h3fffd, 1'b1);
            fab.idle();
            drain();
            pop(36'h9);
            pop(36'h33);
            chk("lat", lat[i], fab.lastLat);
        end
        $display("testAddSub done");
    endtask

    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        testRegs();
        testAccum();
        testOvf();
        testAddSub();
        tallyAndFinish();
    end
endmodule

`default_nettype wire
